// *** rtl/rcs_pkg.sv ***
// Constants and types of the reset cause and stop recovery block.
// Assumes one 125 MHz system clock and an AHB-Lite register port.
// Behaviour
// RQ1 - Fault detect forces reset, then sets fault flag
// RQ2 - Recovery holds core for 66 oscillator cycles
// RQ3 - Recovery touches only status and oscillator control
// RQ4 - After recovery fetch vector at 0002h/0003h
// RQ5 - Every recovery sets the stop recovery flag
// RQ6 - Watchdog in stop recovers, sets watchdog+stop flags
// RQ7 - Exception-mode watchdog: recovery first, then exception
// RQ8 - Enabled GPIO level change either way wakes
// RQ9 - Wake pulses under 10 ns are rejected
// RQ10 - Pin as fault input has no reset effect
// RQ11 - Select bit writable after 14h then 92h
// RQ12 - Software writes unlock bytes then value, in order
// RQ13 - Software select write overrides option bit value
// RQ14 - Select 0 reset input, 1 fault zero input
// RQ15 - After reset select is inverse option bit
// RQ16 - Each event refreshes all cause flags together
// RQ17 - Fixed status layout, cause flags read only
// RQ18 - Power-on sets only power; pin sets only pin
// RQ19 - Watchdog reset sets watchdog and pin flags
// RQ20 - Debugger reset sets power and pin flags
// RQ21 - Fault reset sets pin+fault; simultaneous resets merge
// RQ22 - GPIO wake: stop only; watchdog wake: stop+watchdog
// RQ23 - Out-of-order write clears unlock, keeps select
package rcs_pkg;
  localparam logic [11:0] RCS_ADDR_STATUS  = 12'hff0;  // Byte address of status register
  localparam int          RCS_SEL_BIT      = 0;        // Pin function select position
  localparam int          RCS_STOP_BIT     = 6;        // Stop recovery flag position
  localparam logic [7:0]  RCS_CAUSE_MASK   = 8'hf8;    // Cause flags, bits 7..3
  localparam logic [7:0]  RCS_PAT_POR      = 8'h80;    // Power-on, also reset value
  localparam logic [7:0]  RCS_PAT_EXT      = 8'h10;    // Reset pin
  localparam logic [7:0]  RCS_PAT_WDT_RST  = 8'h30;    // Watchdog reset
  localparam logic [7:0]  RCS_PAT_DBG      = 8'h90;    // Debugger reset
  localparam logic [7:0]  RCS_PAT_FLT      = 8'h18;    // Fault detector reset
  localparam logic [7:0]  RCS_PAT_SMR_GPIO = 8'h40;    // GPIO wake recovery
  localparam logic [7:0]  RCS_PAT_SMR_WDT  = 8'h60;    // Watchdog wake recovery
  localparam logic [7:0]  RCS_UNLOCK_FIRST = 8'h14;    // First unlock byte
  localparam logic [7:0]  RCS_UNLOCK_NEXT  = 8'h92;    // Second unlock byte
  localparam logic [15:0] RCS_VEC_ADDR_HI  = 16'h0002; // Vector high byte address
  localparam logic [15:0] RCS_VEC_ADDR_LO  = 16'h0003; // Vector low byte address
  localparam int          RCS_GPIO_N       = 8;        // Wake capable pins
  localparam int          RCS_CLK_NS       = 8;        // System clock period
  localparam int          RCS_GLITCH_NS    = 10;       // Shortest accepted wake pulse
  localparam int          RCS_GLITCH_CYC   = (RCS_GLITCH_NS + RCS_CLK_NS - 1) / RCS_CLK_NS;
  localparam int          RCS_HOLD_OSC_CYC = 66;       // Hold length, oscillator cycles
  localparam int          RCS_OSC_DIV      = 23;       // System cycles per oscillator cycle
  localparam int          RCS_HOLD_SYS_CYC = RCS_HOLD_OSC_CYC * RCS_OSC_DIV;
  typedef enum logic [1:0] {RCS_RUN, RCS_RESET, RCS_RECOVER} rcs_state_e;
  typedef enum logic [1:0] {RCS_LK_IDLE, RCS_LK_FIRST, RCS_LK_OPEN} rcs_lock_e;
endpackage : rcs_pkg

// *** rtl/rcs_hold_if.sv ***
// Start and completion handshake of the reset hold timer.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface rcs_hold_if;
  logic start;  // One-cycle pulse, (re)starts the hold
  logic busy;   // Hold in progress
  logic done;   // One-cycle pulse, hold elapsed
  modport ctl (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface : rcs_hold_if
`default_nettype wire

// *** rtl/rcs_hold_timer.sv ***
// Hold timer: counts oscillator cycles derived from the system clock.
// Assumes start is a single-cycle pulse from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module rcs_hold_timer (
  input wire logic  hclk,
  input wire logic  hresetn,
  rcs_hold_if.tmr   hold
);
  import rcs_pkg::*;
  logic [4:0]  div_ff;   // Oscillator tick divider
  logic [6:0]  cnt_ff;   // Oscillator cycles elapsed
  logic        busy_ff;  // Hold running
  logic        done_ff;  // Completion pulse
  logic [10:0] len_ff;   // Busy cycle count, checked only
  logic        tick;     // One-cycle oscillator enable
  logic        fin;      // Last tick of the hold
  assign tick = (div_ff == 5'(RCS_OSC_DIV - 1));
  assign fin  = busy_ff && tick && (cnt_ff == 7'(RCS_HOLD_OSC_CYC - 1));
  // Divider and counter restart on every start so a retrigger gets a full hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff  <= 5'h00;
      cnt_ff  <= 7'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= fin && !hold.start;
      if (hold.start) begin
        div_ff  <= 5'h00;
        cnt_ff  <= 7'h00;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        div_ff <= tick ? 5'h00 : div_ff + 5'h01;
        if (tick) begin
          cnt_ff <= cnt_ff + 7'h01;
        end
        if (fin) begin
          busy_ff <= 1'b0;  // see RQ2
        end
      end
    end
  end
  // Helper length counter for the hold check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      len_ff <= 11'h000;
    end else begin
      len_ff <= hold.start ? 11'h000 : (busy_ff ? len_ff + 11'h001 : len_ff);
    end
  end
  assign hold.busy = busy_ff;
  assign hold.done = done_ff;
  a_hold_length: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ2
    done_ff |-> len_ff == 11'(RCS_HOLD_SYS_CYC)) else $error("hold length wrong");
endmodule : rcs_hold_timer
`default_nettype wire

// *** rtl/rcs_wake_filter.sv ***
// Wake filter: per-pin glitch rejection and level change detection.
// Assumes pin levels are already synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module rcs_wake_filter (
  input wire logic                           hclk,
  input wire logic                           hresetn,
  input wire logic [rcs_pkg::RCS_GPIO_N-1:0] gpio_in,
  input wire logic [rcs_pkg::RCS_GPIO_N-1:0] wake_enable,
  output logic                               wake_event
);
  import rcs_pkg::*;
  logic                  loaded_ff;  // Levels captured after reset
  logic [RCS_GPIO_N-1:0] level_ff;   // Accepted, filtered level
  logic [RCS_GPIO_N-1:0] evt;        // Accepted change this cycle
  logic                  wake_ff;    // Registered wake request
  // First cycle after release takes the pin levels, so a high pin is no wake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) loaded_ff <= 1'b0;
    else          loaded_ff <= 1'b1;
  end
  for (genvar i = 0; i < RCS_GPIO_N; i++) begin : g_pin
    logic [1:0] cnt_ff;  // Cycles the new level has held
    assign evt[i] = loaded_ff && (gpio_in[i] != level_ff[i])
                    && (cnt_ff == 2'(RCS_GLITCH_CYC - 1));
    // A change counts only after holding the glitch time; disabled pins just track
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cnt_ff      <= 2'h0;
        level_ff[i] <= 1'b0;
      end else if (!loaded_ff || evt[i]) begin
        cnt_ff      <= 2'h0;
        level_ff[i] <= gpio_in[i];  // see RQ8
      end else begin
        cnt_ff <= (gpio_in[i] != level_ff[i]) ? cnt_ff + 2'h1 : 2'h0;  // see RQ9
      end
    end
    a_pulse_filter: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ9
      evt[i] |-> $past(gpio_in[i]) == gpio_in[i]) else $error("short pulse accepted");
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wake_ff <= 1'b0;
    else          wake_ff <= |(evt & wake_enable);  // see RQ8
  end
  assign wake_event = wake_ff;
endmodule : rcs_wake_filter
`default_nettype wire

// *** rtl/rcs_reset_cause.sv ***
// Reset cause recorder and stop recovery sequencer with its status register.
// Assumes an AHB-Lite master, synchronous event inputs, and that the system
// reset output resets the rest of the chip but not this block.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_cause (
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic                                hreadyout,
  output logic                                hresp,
  output logic [31:0]                         hrdata,
  input  wire logic                           power_on_event,
  input  wire logic                           reset_pin_n,
  input  wire logic                           wdt_timeout,
  input  wire logic                           wdt_reset_mode,
  input  wire logic                           fault_detect,
  input  wire logic                           debugger_reset_req,
  input  wire logic                           stop_mode,
  input  wire logic [rcs_pkg::RCS_GPIO_N-1:0] gpio_in,
  input  wire logic [rcs_pkg::RCS_GPIO_N-1:0] wake_enable,
  input  wire logic                           option_fault_select,
  output logic                                system_reset,
  output logic                                cpu_hold,
  output logic                                osc_ctrl_reset,
  output logic                                vector_fetch,
  output logic [15:0]                         vector_addr_hi,
  output logic [15:0]                         vector_addr_lo,
  output logic                                wdt_exception,
  output logic                                pwm_fault_input_zero_n,
  output logic                                pin_function_select
);
  import rcs_pkg::*;

  rcs_hold_if hold ();  // Hold timer handshake

  rcs_state_e st_ff;           // Sequencer state
  rcs_state_e nxt_st;          // Next sequencer state
  rcs_lock_e  lk_ff;           // Unlock progress
  logic [7:0] cause_ff;        // Cause flags, low bits zero
  logic [7:0] pend_ff;         // Causes gathered during a hold
  logic [7:0] nxt_pend;        // Next gathered causes
  logic       sel_ff;          // Pin function select
  logic       strap_ff;        // Option bit load pending
  logic       exc_ff;          // Watchdog exception owed after recovery
  logic       sysrst_ff;       // Full reset output
  logic       hold_ff;         // Core hold output
  logic       oscrst_ff;       // Oscillator control reset pulse
  logic       vecf_ff;         // Vector fetch pulse
  logic       wexc_ff;         // Watchdog exception pulse
  logic       fault_pin_ff;    // Fault input routed from the shared pin
  logic       wr_ff;           // Data phase of a status write
  logic [31:0] rdata_ff;       // Read data
  logic       wake;            // Filtered GPIO wake request
  logic       ext_req;         // Pin acting as reset and asserted
  logic [7:0] full_pat;        // Causes of a full reset this cycle
  logic [7:0] rec_pat;         // Causes of a recovery this cycle
  logic       full_hit;        // Any full reset source
  logic       rec_hit;         // Any recovery source
  logic       addr_ok;         // Valid address phase
  logic       reg_hit;         // Address phase hits the status register
  logic       wr_hit;          // Status write takes effect now
  logic [7:0] wbyte;           // Written byte
  logic       release_c;       // Hold ends this cycle
  logic       done_seen_ff;    // Hold timer has finished this reset

  rcs_wake_filter u_wake (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .gpio_in     (gpio_in),
    .wake_enable (wake_enable),
    .wake_event  (wake)
  );

  rcs_hold_timer u_hold (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hold    (hold.tmr)
  );

  // The shared pin resets only while selected as reset input
  assign ext_req = !reset_pin_n && !sel_ff;  // see RQ10 see RQ14

  // Cause patterns; simultaneous sources simply merge
  always_comb begin
    full_pat = 8'h00;
    if (power_on_event) full_pat = full_pat | RCS_PAT_POR;  // see RQ18
    if (ext_req) full_pat = full_pat | RCS_PAT_EXT;  // see RQ18
    if (wdt_timeout && wdt_reset_mode && !stop_mode) begin
      full_pat = full_pat | RCS_PAT_WDT_RST;  // see RQ19
    end
    if (debugger_reset_req && !stop_mode) full_pat = full_pat | RCS_PAT_DBG;  // see RQ20
    if (fault_detect) full_pat = full_pat | RCS_PAT_FLT;  // see RQ1 see RQ21
    rec_pat = 8'h00;
    if (stop_mode && wake) rec_pat = rec_pat | RCS_PAT_SMR_GPIO;  // see RQ22
    if (stop_mode && wdt_timeout) rec_pat = rec_pat | RCS_PAT_SMR_WDT;  // see RQ6 see RQ22
  end
  assign full_hit = (full_pat != 8'h00);
  assign rec_hit  = (rec_pat != 8'h00);

  // A reset held by the pin lasts until both the hold and the pin are done
  assign release_c = (st_ff == RCS_RESET) ? ((done_seen_ff || hold.done) && !ext_req)
                                          : ((st_ff == RCS_RECOVER) && hold.done && !full_hit);

  // Sequencer next state; a full reset always beats a recovery
  always_comb begin
    nxt_st   = st_ff;
    nxt_pend = pend_ff;
    case (st_ff)
      RCS_RUN: begin
        if (full_hit) begin
          nxt_st   = RCS_RESET;
          nxt_pend = full_pat;
        end else if (rec_hit) begin
          nxt_st   = RCS_RECOVER;  // see RQ6 see RQ8
          nxt_pend = rec_pat;
        end
      end
      RCS_RESET: begin
        nxt_pend = pend_ff | full_pat;  // see RQ21
        if (release_c) nxt_st = RCS_RUN;
      end
      RCS_RECOVER: begin
        if (full_hit) begin
          nxt_st   = RCS_RESET;
          nxt_pend = full_pat;
        end else if (release_c) begin
          nxt_st = RCS_RUN;
        end
      end
      default: begin
        nxt_st = RCS_RUN;
      end
    endcase
  end

  // Timer starts on entry to a hold; pending causes never restart it
  assign hold.start = (st_ff != RCS_RESET) && (nxt_st != st_ff) && (nxt_st != RCS_RUN);

  // State, gathered causes and the fact that the hold has elapsed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff        <= RCS_RUN;
      pend_ff      <= 8'h00;
      done_seen_ff <= 1'b0;
    end else begin
      st_ff        <= nxt_st;
      pend_ff      <= nxt_pend;
      done_seen_ff <= hold.start ? 1'b0 : (done_seen_ff || hold.done);
    end
  end

  // Cause flags are replaced as a whole at the end of every hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_ff <= RCS_PAT_POR;  // see RQ18
    end else if (release_c) begin
      cause_ff <= pend_ff & RCS_CAUSE_MASK;  // see RQ16 see RQ5 see RQ1
    end
  end

  // Outputs follow the next state so they line up with the state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysrst_ff <= 1'b0;
      hold_ff   <= 1'b0;
      oscrst_ff <= 1'b0;
      vecf_ff   <= 1'b0;
    end else begin
      sysrst_ff <= (nxt_st == RCS_RESET);  // see RQ3
      hold_ff   <= (nxt_st != RCS_RUN);  // see RQ2
      oscrst_ff <= hold.start && (nxt_st == RCS_RECOVER);  // see RQ3
      vecf_ff   <= release_c;  // see RQ4
    end
  end

  // Exception-mode watchdog wake: exception only after the vector fetch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exc_ff  <= 1'b0;
      wexc_ff <= 1'b0;
    end else begin
      if (hold.start) begin
        exc_ff <= (nxt_st == RCS_RECOVER) && stop_mode && wdt_timeout && !wdt_reset_mode;
      end else if (vecf_ff) begin
        exc_ff <= 1'b0;
      end
      wexc_ff <= vecf_ff && exc_ff && (st_ff == RCS_RUN);  // see RQ7
    end
  end

  // The shared pin feeds the fault input only while so selected
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) fault_pin_ff <= 1'b1;
    else          fault_pin_ff <= sel_ff ? reset_pin_n : 1'b1;  // see RQ14
  end

  // AHB-Lite slave, zero wait states, always OKAY
  assign addr_ok = hsel && hready && htrans[1];
  assign reg_hit = addr_ok && (haddr[11:0] == RCS_ADDR_STATUS);
  assign wr_hit  = wr_ff;
  assign wbyte   = hwdata[7:0];

  // Write data arrives one cycle after its address; reads sample at address time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff    <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wr_ff <= reg_hit && hwrite;
      if (reg_hit && !hwrite) begin
        rdata_ff <= {24'h00_0000, cause_ff[7:3], 2'b00, sel_ff};  // see RQ17
      end else if (addr_ok) begin
        rdata_ff <= 32'h0000_0000;
      end
    end
  end

  // Unlock: two ordered bytes, then one value write; anything else relocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lk_ff <= RCS_LK_IDLE;
    end else if (wr_hit) begin
      case (lk_ff)
        RCS_LK_IDLE: begin
          lk_ff <= (wbyte == RCS_UNLOCK_FIRST) ? RCS_LK_FIRST : RCS_LK_IDLE;  // see RQ11
        end
        RCS_LK_FIRST: begin
          lk_ff <= (wbyte == RCS_UNLOCK_NEXT) ? RCS_LK_OPEN : RCS_LK_IDLE;  // see RQ23
        end
        default: begin
          lk_ff <= RCS_LK_IDLE;  // see RQ12
        end
      endcase
    end
  end

  // Select bit: inverse of option bit after reset, unlocked write overrides it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_ff   <= 1'b0;
      strap_ff <= 1'b1;
    end else begin
      strap_ff <= (st_ff == RCS_RESET) && release_c;
      if (wr_hit && (lk_ff == RCS_LK_OPEN)) begin
        sel_ff <= wbyte[RCS_SEL_BIT];  // see RQ11 see RQ13
      end else if (strap_ff) begin
        sel_ff <= !option_fault_select;  // see RQ15
      end
    end
  end

  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign hrdata                 = rdata_ff;
  assign system_reset           = sysrst_ff;
  assign cpu_hold               = hold_ff;
  assign osc_ctrl_reset         = oscrst_ff;
  assign vector_fetch           = vecf_ff;
  assign vector_addr_hi         = RCS_VEC_ADDR_HI;  // see RQ4
  assign vector_addr_lo         = RCS_VEC_ADDR_LO;
  assign wdt_exception          = wexc_ff;
  assign pwm_fault_input_zero_n = fault_pin_ff;
  assign pin_function_select    = sel_ff;

  // Checks
  sequence s_recover_end;
    (st_ff == RCS_RECOVER) && release_c ##1 vecf_ff;
  endsequence
  a_fault_resets: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ1
    fault_detect && (st_ff != RCS_RESET) |=> sysrst_ff ##0 pend_ff[3])
    else $error("fault did not force reset");
  a_recover_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ3
    (st_ff == RCS_RECOVER) |-> !sysrst_ff && hold_ff && (hold.busy || hold.done))
    else $error("recovery reset chip");
  a_stop_flag_set: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ5
    s_recover_end |-> cause_ff[RCS_STOP_BIT] && !cause_ff[4]) else $error("stop flag not set");
  a_wdt_stop_wake: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ6
    (st_ff == RCS_RUN) && stop_mode && wdt_timeout && !full_hit
    |=> (st_ff == RCS_RECOVER) && oscrst_ff && pend_ff[5]) else $error("watchdog wake wrong");
  a_exc_after_rec: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ7
    wexc_ff |-> $past(vecf_ff) && !hold_ff) else $error("exception before recovery done");
  a_gpio_wake: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ8
    (st_ff == RCS_RUN) && stop_mode && wake && !full_hit |=> (st_ff == RCS_RECOVER))
    else $error("gpio wake ignored");
  a_pin_as_fault: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ10
    sel_ff && !reset_pin_n |=> !pend_ff[4] || $past(st_ff == RCS_RESET) || $past(full_hit))
    else $error("fault pin caused reset");
  a_unlock_write: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ11
    wr_hit && (lk_ff == RCS_LK_OPEN) |=> (sel_ff == $past(wbyte[0])) && (lk_ff == RCS_LK_IDLE))
    else $error("unlocked write lost");
  a_locked_keep: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ23
    wr_hit && (lk_ff != RCS_LK_OPEN) && !strap_ff |=> $stable(sel_ff))
    else $error("locked write changed select");
  a_strap_load: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ15
    strap_ff && !(wr_hit && (lk_ff == RCS_LK_OPEN)) |=> sel_ff == !$past(option_fault_select))
    else $error("select not loaded from option");
endmodule : rcs_reset_cause
`default_nettype wire

// *** verif/test_rcs_reset_cause.sv ***
// Testbench of the reset cause recorder: register port, unlock, reset and wake events.
// Assumes the zero wait state AHB-Lite slave of the design and a 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_rcs_reset_cause;
  import rcs_pkg::*;
  localparam logic [31:0] SA = {20'h0, RCS_ADDR_STATUS};  // Status register address
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_dp = 0, opt = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic        hreadyout, hresp, sys_rst, hold, osc_rst, vfetch, wexc, pwm_n, sel;
  logic        por_ev = 0, pin_n = 1, wdt_to = 0, wdt_rm = 1, fault_logic_cause_flag = 0, dbg = 0, stop = 0;
  logic [15:0] vhi, vlo;
  logic [7:0]  gpio = 0, wen = 8'hff;
  logic [31:0] q[$];                                       // Expected read data, oldest first
  logic [6:0]  ms[8] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h11, 7'h60, 7'h42};
  logic [7:0]  ps[8] = '{8'h18, 8'h30, 8'h90, 8'h10, 8'h80, 8'h99, 8'h41, 8'h61};
  int          failures = 0, cmp_count = 0;
  always #4 hclk = ~hclk;
  rcs_reset_cause u_rcs_reset_cause (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .power_on_event(por_ev), .reset_pin_n(pin_n), .wdt_timeout(wdt_to),
    .wdt_reset_mode(wdt_rm), .fault_detect(fault_logic_cause_flag), .debugger_reset_req(dbg), .stop_mode(stop),
    .gpio_in(gpio), .wake_enable(wen), .option_fault_select(opt), .system_reset(sys_rst),
    .cpu_hold(hold), .osc_ctrl_reset(osc_rst), .vector_fetch(vfetch), .vector_addr_hi(vhi),
    .vector_addr_lo(vlo), .wdt_exception(wexc), .pwm_fault_input_zero_n(pwm_n),
    .pin_function_select(sel));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One single transfer; hready is sampled before each phase moves on
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 0; hwdata <= d; rd_dp <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp <= 0;
  endtask : ahb
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    q.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask : rd
  // Read data is taken at the edge that ends the data phase
  always @(posedge hclk) if (rd_dp) chk(hrdata, q.pop_front());
  // One event mask: 0 fault, 1 watchdog, 2 debugger, 3 pin, 4 power, 5 gpio, 6 stop
  task automatic ev(input logic [6:0] m, input logic [7:0] p);
    int i, n;
    logic [2:0] b;
    b = 3'($urandom);
    i = 0;
    n = 0;
    @(posedge hclk); stop <= m[6]; wdt_rm <= !m[6];
    @(posedge hclk); fault_logic_cause_flag <= m[0]; wdt_to <= m[1]; dbg <= m[2]; pin_n <= !m[3]; por_ev <= m[4];
    if (m[5]) gpio[b] <= !gpio[b];
    @(posedge hclk); fault_logic_cause_flag <= 0; wdt_to <= 0; dbg <= 0; pin_n <= 1; por_ev <= 0; #1;
    while (hold !== 1'b1 && i < 8) begin @(posedge hclk); #1; i++; end
    chk(osc_rst, m[6]);
    chk(sys_rst, !m[6]);
    while (hold === 1'b1 && n < 3000) begin @(posedge hclk); #1; n++; end
    chk(n >= 1516 && n <= 1526, 1);
    chk({vhi, vlo}, 32'h00020003);
    chk(vfetch, 1);
    @(posedge hclk); #1; chk(wexc, m[6] & m[1]);
    @(posedge hclk); stop <= 0;
    rd(SA, {24'h0, p});
  endtask : ev
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  initial begin
    void'($urandom(53340));
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    rd(SA, 32'h80);
    rd(32'hff4, 32'h0);
    ahb(1, SA, 32'hff); rd(SA, 32'h80);
    ahb(1, SA, 32'h14); ahb(1, SA, 32'h92); ahb(1, SA, 32'h01); rd(SA, 32'h81);
    chk({hresp, sel}, 32'h1);
    ahb(1, SA, 32'h14); ahb(1, SA, 32'h20 | ($urandom & 32'hf));
    ahb(1, SA, 32'h92); ahb(1, SA, 32'h00); rd(SA, 32'h81);
    // Pin now serves as fault input: a low level must not reset
    @(posedge hclk); pin_n <= 0;
    repeat (4) @(posedge hclk);
    #1; chk({sys_rst, pwm_n}, 0);
    // Short pulse on an enabled pin, lasting change on a disabled one: no wake
    @(posedge hclk); pin_n <= 1; stop <= 1; gpio[1:0] <= 2'b11; wen <= 8'hfe;
    @(posedge hclk); gpio[1] <= 0;
    repeat (6) @(posedge hclk);
    #1; chk(hold, 0);
    @(posedge hclk); stop <= 0; wen <= 8'hff;
    for (int k = 0; k < 8; k++) begin
      if (k == 5) opt <= 0;  // Programmed option bit: select reloads as 1
      ev(ms[k], ps[k]);
    end
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge hclk);
    failures++;
    stop_test();
  end
endmodule : test_rcs_reset_cause
`default_nettype wire
